/* rtl/scti_synth_cal_regs.sv */
// Function
// (RQ1) Pump enable field zero skips charge-pump calibration stage; nonzero keeps it.
// (RQ2) Pump calibration result is a four-bit code in low pump bits.
// (RQ3) Software loads pump upper bits with calibration configuration before calibrating.
// (RQ4) VCO register bit five selects high core when one, low when zero.
// (RQ5) Five-bit VCO current field holds calibration result; software may override.
// (RQ6) Six-bit coarse tuning field holds calibration result, software readable and writable.
// (RQ7) VCO selection enable bit includes selection stage when one; resets to one.
// (RQ8) Reserved and test registers lose contents in sleep; rewrite after waking.
// (RQ9) Wake forces second test register internally to 0x88 or 0x81.
// (RQ10) Second test register reads 0x88 after wake regardless of retention.
// (RQ11) Wake forces first test register internally to 0x31 or 0x35.
// (RQ12) First test register reads 0x31 after wake regardless of retention.
// (RQ13) Unused bits read zero and writes to them change nothing.
// (RQ14) Part and revision identification registers are read-only eight-bit values.
`timescale 1ns/1ps
`include "scti_params.svh"

module scti_synth_cal_regs #(
  parameter logic [7:0] PART_ID = 8'h5A,  // Arbitrary value
  parameter logic [7:0] REV_ID  = 8'h0C   // Arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [5:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rd_data,
  input  wire logic        sleep_request,
  input  wire logic        converter_retention_setting,
  input  wire logic        cal_done,
  input  wire logic [3:0]  cal_pump_code,
  input  wire logic [4:0]  cal_vco_current,
  input  wire logic [5:0]  cal_coarse_tune,
  output logic      [1:0]  pump_cal_config,
  output logic             pump_stage_enable,
  output logic      [3:0]  pump_current_code,
  output logic             oscillator_core_high_select,
  output logic      [4:0]  vco_current_code,
  output logic      [5:0]  coarse_tune_code,
  output logic      [6:0]  cal_control,
  output logic             vco_select_stage_enable,
  output logic      [7:0]  reserved_cfg_a,
  output logic      [7:0]  reserved_cfg_b,
  output logic      [7:0]  reserved_cfg_c,
  output logic      [7:0]  test_two_analog,
  output logic      [7:0]  test_one_analog,
  output logic      [7:0]  test_zero_value,
  output logic             asleep
);

  // ****************************************
  // State
  // ****************************************
  scti_pkg::scti_power_t power_q;
  scti_pkg::scti_power_t power_d;
  scti_pkg::scti_byte_t  pump_q;
  scti_pkg::scti_byte_t  pump_d;
  scti_pkg::scti_byte_t  vco_cur_q;
  scti_pkg::scti_byte_t  vco_cur_d;
  scti_pkg::scti_byte_t  coarse_q;
  scti_pkg::scti_byte_t  coarse_d;
  scti_pkg::scti_byte_t  control_q;
  scti_pkg::scti_byte_t  control_d;
  scti_pkg::scti_byte_t  rsv_a_q;
  scti_pkg::scti_byte_t  rsv_a_d;
  scti_pkg::scti_byte_t  rsv_b_q;
  scti_pkg::scti_byte_t  rsv_b_d;
  scti_pkg::scti_byte_t  rsv_c_q;
  scti_pkg::scti_byte_t  rsv_c_d;
  scti_pkg::scti_byte_t  test_two_q;
  scti_pkg::scti_byte_t  test_two_d;
  scti_pkg::scti_byte_t  test_two_an_q;
  scti_pkg::scti_byte_t  test_two_an_d;
  scti_pkg::scti_byte_t  test_one_q;
  scti_pkg::scti_byte_t  test_one_d;
  scti_pkg::scti_byte_t  test_one_an_q;
  scti_pkg::scti_byte_t  test_one_an_d;
  scti_pkg::scti_byte_t  test_zero_q;
  scti_pkg::scti_byte_t  test_zero_d;
  scti_pkg::scti_byte_t  rd_data_q;
  scti_pkg::scti_byte_t  rd_data_d;
  logic                  pump_stage_q;
  logic                  pump_stage_d;
  logic                  wr_ok;
  logic                  wake;
  logic                  asleep_q;
  logic                  asleep_d;
  scti_pkg::scti_byte_t  wake_two_value;
  scti_pkg::scti_byte_t  wake_one_value;

  function automatic logic addr_hit(input logic [5:0] a, input logic [5:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  // ****************************************
  // Power state
  // ****************************************
  always_comb begin
    power_d = power_q;
    wake    = 1'b0;
    case (power_q)
      scti_pkg::SCTI_AWAKE: begin
        if (sleep_request) begin
          power_d = scti_pkg::SCTI_ASLEEP;
        end
      end
      scti_pkg::SCTI_ASLEEP: begin
        if (!sleep_request) begin
          power_d = scti_pkg::SCTI_AWAKE;
          wake    = 1'b1;
        end
      end
      default: begin
        power_d = scti_pkg::SCTI_AWAKE;
      end
    endcase
    asleep_d = (power_d == scti_pkg::SCTI_ASLEEP);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      power_q  <= scti_pkg::SCTI_AWAKE;
      asleep_q <= 1'b0;
    end else begin
      power_q  <= power_d;
      asleep_q <= asleep_d;
    end
  end

  // ****************************************
  // Wake values
  // ****************************************
  // Readback keeps reset values; only the analog copies see retention
  always_comb begin
    wake_two_value = `SCTI_RST_TEST_TWO;
    wake_one_value = `SCTI_RST_TEST_ONE;
    if (converter_retention_setting) begin
      wake_two_value = `SCTI_WAKE_TEST_TWO_RET;  // [RQ9]
      wake_one_value = `SCTI_WAKE_TEST_ONE_RET;  // [RQ11]
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  assign wr_ok = reg_wr_en && (power_q == scti_pkg::SCTI_AWAKE);

  always_comb begin
    pump_d     = pump_q;
    vco_cur_d  = vco_cur_q;
    coarse_d   = coarse_q;
    control_d  = control_q;
    rsv_a_d    = rsv_a_q;
    rsv_b_d    = rsv_b_q;
    rsv_c_d    = rsv_c_q;
    test_two_d    = test_two_q;
    test_two_an_d = test_two_an_q;
    test_one_d    = test_one_q;
    test_one_an_d = test_one_an_q;
    test_zero_d   = test_zero_q;
    if (wr_ok) begin
      if (addr_hit(reg_addr, `SCTI_ADDR_PUMP)) begin
        pump_d = reg_wr_data;  // [RQ3]
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_VCO_CURRENT)) begin
        vco_cur_d = reg_wr_data & `SCTI_MASK_VCO_CURRENT;  // [RQ4] [RQ5] [RQ13]
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_COARSE_TUNE)) begin
        coarse_d = reg_wr_data & `SCTI_MASK_COARSE_TUNE;  // [RQ6] [RQ13]
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_CONTROL)) begin
        control_d = reg_wr_data & `SCTI_MASK_CONTROL;  // [RQ13]
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_RSV_A)) begin
        rsv_a_d = reg_wr_data;
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_RSV_B)) begin
        rsv_b_d = reg_wr_data;
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_RSV_C)) begin
        rsv_c_d = reg_wr_data;
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_TEST_TWO)) begin
        test_two_d    = reg_wr_data;
        test_two_an_d = reg_wr_data;
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_TEST_ONE)) begin
        test_one_d    = reg_wr_data;
        test_one_an_d = reg_wr_data;
      end
      if (addr_hit(reg_addr, `SCTI_ADDR_TEST_ZERO)) begin
        test_zero_d = reg_wr_data;  // [RQ7]
      end
    end
    // Calibration results win over a software write in the same cycle
    if (cal_done) begin
      pump_d[`SCTI_PUMP_CODE_HI:`SCTI_PUMP_CODE_LO] = cal_pump_code;  // [RQ2]
      vco_cur_d[`SCTI_VCO_CUR_HI:`SCTI_VCO_CUR_LO]  = cal_vco_current;  // [RQ5]
      coarse_d[`SCTI_COARSE_HI:`SCTI_COARSE_LO]     = cal_coarse_tune;  // [RQ6]
    end
    // Volatile group restored on wake; analog copies forced by retention
    if (wake) begin
      rsv_a_d = `SCTI_RST_RSV_A;  // [RQ8]
      rsv_b_d = `SCTI_RST_RSV_B;  // [RQ8]
      rsv_c_d = `SCTI_RST_RSV_C;  // [RQ8]
      test_zero_d   = `SCTI_RST_TEST_ZERO;  // [RQ8]
      test_two_d    = `SCTI_RST_TEST_TWO;  // [RQ10]
      test_one_d    = `SCTI_RST_TEST_ONE;  // [RQ12]
      test_two_an_d = wake_two_value;  // [RQ9]
      test_one_an_d = wake_one_value;  // [RQ11]
    end
  end

  always_comb begin
    pump_stage_d = (pump_d[`SCTI_PUMP_EN_HI:`SCTI_PUMP_EN_LO] != 2'b00);  // [RQ1]
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pump_q       <= `SCTI_RST_PUMP;
      vco_cur_q    <= `SCTI_RST_VCO_CURRENT;
      coarse_q     <= `SCTI_RST_COARSE_TUNE;
      control_q    <= `SCTI_RST_CONTROL;
      rsv_a_q      <= `SCTI_RST_RSV_A;
      rsv_b_q      <= `SCTI_RST_RSV_B;
      rsv_c_q      <= `SCTI_RST_RSV_C;
      test_two_q    <= `SCTI_RST_TEST_TWO;
      test_two_an_q <= `SCTI_RST_TEST_TWO;
      test_one_q    <= `SCTI_RST_TEST_ONE;
      test_one_an_q <= `SCTI_RST_TEST_ONE;
      test_zero_q   <= `SCTI_RST_TEST_ZERO;
      pump_stage_q <= 1'b1;
    end else begin
      pump_q       <= pump_d;
      vco_cur_q    <= vco_cur_d;
      coarse_q     <= coarse_d;
      control_q    <= control_d;
      rsv_a_q      <= rsv_a_d;
      rsv_b_q      <= rsv_b_d;
      rsv_c_q      <= rsv_c_d;
      test_two_q    <= test_two_d;
      test_two_an_q <= test_two_an_d;
      test_one_q    <= test_one_d;
      test_one_an_q <= test_one_an_d;
      test_zero_q   <= test_zero_d;
      pump_stage_q <= pump_stage_d;
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    rd_data_d = rd_data_q;
    if (reg_rd_en) begin
      rd_data_d = 8'h00;  // [RQ13]
      case (reg_addr)
        `SCTI_ADDR_PUMP:        rd_data_d = pump_q;
        `SCTI_ADDR_VCO_CURRENT: rd_data_d = vco_cur_q & `SCTI_MASK_VCO_CURRENT;  // [RQ13]
        `SCTI_ADDR_COARSE_TUNE: rd_data_d = coarse_q & `SCTI_MASK_COARSE_TUNE;   // [RQ13]
        `SCTI_ADDR_CONTROL:     rd_data_d = control_q & `SCTI_MASK_CONTROL;      // [RQ13]
        `SCTI_ADDR_RSV_A:       rd_data_d = rsv_a_q;
        `SCTI_ADDR_RSV_B:       rd_data_d = rsv_b_q;
        `SCTI_ADDR_RSV_C:       rd_data_d = rsv_c_q;
        `SCTI_ADDR_TEST_TWO:    rd_data_d = test_two_q;  // [RQ10]
        `SCTI_ADDR_TEST_ONE:    rd_data_d = test_one_q;  // [RQ12]
        `SCTI_ADDR_TEST_ZERO:   rd_data_d = test_zero_q;
        `SCTI_ADDR_PART_ID:     rd_data_d = PART_ID;  // [RQ14]
        `SCTI_ADDR_REV_ID:      rd_data_d = REV_ID;   // [RQ14]
        default:                rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rd_data                 = rd_data_q;
  assign pump_cal_config             = pump_q[`SCTI_PUMP_CFG_HI:`SCTI_PUMP_CFG_LO];
  assign pump_stage_enable           = pump_stage_q;
  assign pump_current_code           = pump_q[`SCTI_PUMP_CODE_HI:`SCTI_PUMP_CODE_LO];
  assign oscillator_core_high_select = vco_cur_q[`SCTI_VCO_CORE_BIT];  // [RQ4]
  assign vco_current_code            = vco_cur_q[`SCTI_VCO_CUR_HI:`SCTI_VCO_CUR_LO];
  assign coarse_tune_code            = coarse_q[`SCTI_COARSE_HI:`SCTI_COARSE_LO];
  assign cal_control                 = control_q[`SCTI_CONTROL_HI:`SCTI_CONTROL_LO];
  assign vco_select_stage_enable     = test_zero_q[`SCTI_VCO_SEL_EN_BIT];  // [RQ7]
  assign reserved_cfg_a              = rsv_a_q;
  assign reserved_cfg_b              = rsv_b_q;
  assign reserved_cfg_c              = rsv_c_q;
  assign test_two_analog             = test_two_an_q;
  assign test_one_analog             = test_one_an_q;
  assign test_zero_value             = test_zero_q;
  assign asleep                      = asleep_q;

endmodule : scti_synth_cal_regs

/* rtl/scti_params.svh */
`ifndef SCTI_PARAMS_SVH
`define SCTI_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define SCTI_ADDR_W            6
`define SCTI_ADDR_PUMP         6'h23
`define SCTI_ADDR_VCO_CURRENT  6'h24
`define SCTI_ADDR_COARSE_TUNE  6'h25
`define SCTI_ADDR_CONTROL      6'h26
`define SCTI_ADDR_RSV_A        6'h29
`define SCTI_ADDR_RSV_B        6'h2A
`define SCTI_ADDR_RSV_C        6'h2B
`define SCTI_ADDR_TEST_TWO     6'h2C
`define SCTI_ADDR_TEST_ONE     6'h2D
`define SCTI_ADDR_TEST_ZERO    6'h2E
`define SCTI_ADDR_PART_ID      6'h30
`define SCTI_ADDR_REV_ID       6'h31

// ****************************************
// Field positions
// ****************************************
`define SCTI_PUMP_CFG_HI       7
`define SCTI_PUMP_CFG_LO       6
`define SCTI_PUMP_EN_HI        5
`define SCTI_PUMP_EN_LO        4
`define SCTI_PUMP_CODE_HI      3
`define SCTI_PUMP_CODE_LO      0
`define SCTI_VCO_CORE_BIT      5
`define SCTI_VCO_CUR_HI        4
`define SCTI_VCO_CUR_LO        0
`define SCTI_COARSE_HI         5
`define SCTI_COARSE_LO         0
`define SCTI_CONTROL_HI        6
`define SCTI_CONTROL_LO        0
`define SCTI_VCO_SEL_EN_BIT    1

// ****************************************
// Reset and wake values
// ****************************************
`define SCTI_RST_PUMP          8'hA9
`define SCTI_RST_VCO_CURRENT   8'h0A
`define SCTI_RST_COARSE_TUNE   8'h20
`define SCTI_RST_CONTROL       8'h0D
`define SCTI_RST_RSV_A         8'h59
`define SCTI_RST_RSV_B         8'h7F
`define SCTI_RST_RSV_C         8'h3F
`define SCTI_RST_TEST_TWO      8'h88
`define SCTI_RST_TEST_ONE      8'h31
`define SCTI_RST_TEST_ZERO     8'h0B
`define SCTI_WAKE_TEST_TWO_RET 8'h81
`define SCTI_WAKE_TEST_ONE_RET 8'h35

// ****************************************
// Used-bit masks
// ****************************************
`define SCTI_MASK_VCO_CURRENT  8'h3F
`define SCTI_MASK_COARSE_TUNE  8'h3F
`define SCTI_MASK_CONTROL      8'h7F

`endif

/* rtl/scti_pkg.sv */
package scti_pkg;

  typedef logic [7:0] scti_byte_t;

  typedef enum logic {
    SCTI_AWAKE,
    SCTI_ASLEEP
  } scti_power_t;

endpackage : scti_pkg

/* tb/scti_regs_props.sv */
`timescale 1ns/1ps
// ****************************************
// Register bank checker
// ****************************************
module scti_regs_props #(
  parameter logic [7:0] PART_ID = 8'h96,  // Arbitrary value
  parameter logic [7:0] REV_ID  = 8'h3B   // Arbitrary value
) (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic [5:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       sleep_request,
  input wire logic       converter_retention_setting,
  input wire logic       cal_done,
  input wire logic [3:0] cal_pump_code,
  input wire logic [4:0] cal_vco_current,
  input wire logic [5:0] cal_coarse_tune,
  input wire logic       pump_stage_enable,
  input wire logic [3:0] pump_current_code,
  input wire logic       oscillator_core_high_select,
  input wire logic [4:0] vco_current_code,
  input wire logic [5:0] coarse_tune_code,
  input wire logic [6:0] cal_control,
  input wire logic       vco_select_stage_enable,
  input wire logic [7:0] reserved_cfg_a,
  input wire logic [7:0] test_two_analog,
  input wire logic [7:0] test_one_analog,
  input wire logic       asleep
);
  logic wr;
  assign wr = reg_wr_en && !asleep;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_pump_stage: assert property (
    wr && reg_addr == 6'h23 |=> pump_stage_enable == |$past(reg_wr_data[5:4]))
    else $error("pump stage enable wrong");
  a_vco_write: assert property (
    wr && reg_addr == 6'h24 && !cal_done |=> oscillator_core_high_select == $past(reg_wr_data[5])
      && vco_current_code == $past(reg_wr_data[4:0])) else $error("vco field write wrong");
  a_coarse_write: assert property (
    wr && reg_addr == 6'h25 && !cal_done |=> coarse_tune_code == $past(reg_wr_data[5:0]))
    else $error("coarse field write wrong");
  a_cal_load: assert property (
    cal_done && !asleep |=> pump_current_code == $past(cal_pump_code) && vco_current_code ==
      $past(cal_vco_current) && coarse_tune_code == $past(cal_coarse_tune))
    else $error("calibration result not loaded");
  a_vsel_write: assert property (
    wr && reg_addr == 6'h2E |=> vco_select_stage_enable == $past(reg_wr_data[1]))
    else $error("vco select enable wrong");
  a_sleep_hold: assert property (
    asleep && sleep_request |=> asleep && $stable(cal_control) && $stable(reserved_cfg_a))
    else $error("state changed while asleep");
  a_wake_forced: assert property (
    asleep && !sleep_request |=> !asleep && test_two_analog == ($past(converter_retention_setting)
      ? 8'h81 : 8'h88) && test_one_analog == ($past(converter_retention_setting) ? 8'h35 : 8'h31))
    else $error("wake values wrong");
  a_id_read: assert property (
    reg_rd_en && reg_addr == 6'h30 |=> reg_rd_data == PART_ID) else $error("part id read wrong");
  c_wake_ret: cover property (asleep && !sleep_request && converter_retention_setting);
  c_cal: cover property (cal_done);
  c_blocked_write: cover property (reg_wr_en && asleep);
endmodule : scti_regs_props

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] PART_ID = 8'hC3;  // Arbitrary value
  localparam logic [7:0] REV_ID  = 8'h4E;  // Arbitrary value
  logic clock = 0, srst = 1, reg_wr_en = 0, reg_rd_en = 0, sleep_request = 0, cal_done = 0;
  logic converter_retention_setting = 0, pump_stage_enable, vco_select_stage_enable, asleep;
  logic oscillator_core_high_select;
  logic [1:0] pump_cal_config;
  logic [7:0] reserved_cfg_b, reserved_cfg_c, test_zero_value;
  logic [5:0] reg_addr = 0, cal_coarse_tune = 0;
  logic [3:0] cal_pump_code = 0;
  logic [4:0] cal_vco_current = 0;
  logic [7:0] reg_wr_data = 0, reg_rd_data, test_two_analog, test_one_analog;
  logic [5:0] ra[12] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E,
                         6'h30, 6'h31};
  logic [7:0] rv[12] = '{8'hA9, 8'h0A, 8'h20, 8'h0D, 8'h59, 8'h7F, 8'h3F, 8'h88, 8'h31, 8'h0B,
                         PART_ID, REV_ID};
  int mismatches = 0, samples_checked = 0, cycles = 0;

  scti_synth_cal_regs #(.PART_ID(PART_ID), .REV_ID(REV_ID)) dut (
    .clock, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .sleep_request,
    .converter_retention_setting, .cal_done, .cal_pump_code, .cal_vco_current, .cal_coarse_tune,
    .pump_cal_config, .pump_stage_enable, .pump_current_code(), .oscillator_core_high_select,
    .vco_current_code(), .coarse_tune_code(), .cal_control(), .vco_select_stage_enable,
    .reserved_cfg_a(), .reserved_cfg_b, .reserved_cfg_c, .test_two_analog, .test_one_analog,
    .test_zero_value, .asleep);

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1;
    @(negedge clock);
    reg_wr_en = 0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd_en = 1;
    @(negedge clock);
    reg_rd_en = 0;
    chk(reg_rd_data, e);
  endtask : rd

  task print_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge clock);
    srst = 0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    chk(pump_stage_enable, 8'h01);
    chk(vco_select_stage_enable, 8'h01);
    for (int e = 0; e < 4; e++) begin
      wr(6'h23, {2'h1, e[1:0], 4'h5});
      chk(pump_stage_enable, (e != 0));
      chk(pump_cal_config, 8'h01);
      rd(6'h23, {2'h1, e[1:0], 4'h5});
    end
    wr(6'h24, 8'hFF);
    chk(oscillator_core_high_select, 8'h01);
    rd(6'h24, 8'h3F);
    wr(6'h24, 8'h0A);
    chk(oscillator_core_high_select, 8'h00);
    wr(6'h25, 8'hFF);
    rd(6'h25, 8'h3F);
    wr(6'h26, 8'hFF);
    rd(6'h26, 8'h7F);
    wr(6'h30, 8'h00);
    rd(6'h30, PART_ID);
    wr(6'h31, 8'hFF);
    rd(6'h31, REV_ID);
    rd(6'h3F, 8'h00);
    @(negedge clock);
    cal_pump_code = 4'h6;
    cal_vco_current = 5'h15;
    cal_coarse_tune = 6'h2B;
    cal_done = 1;
    @(negedge clock);
    cal_done = 0;
    rd(6'h23, 8'h76);
    rd(6'h24, 8'h15);
    rd(6'h25, 8'h2B);
    wr(6'h2E, 8'h09);
    chk(vco_select_stage_enable, 8'h00);
    chk(test_zero_value, 8'h09);
    for (int r = 1; r >= 0; r--) begin
      wr(6'h29, 8'h12);
      wr(6'h2A, 8'h12);
      wr(6'h2B, 8'h12);
      wr(6'h2E, 8'h09);
      wr(6'h2C, 8'h00);
      wr(6'h2D, 8'h00);
      @(negedge clock);
      converter_retention_setting = r[0];
      sleep_request = 1;
      @(negedge clock);
      chk(asleep, 8'h01);
      wr(6'h26, 8'h00);
      sleep_request = 0;
      @(negedge clock);
      chk(asleep, 8'h00);
      chk(test_two_analog, r[0] ? 8'h81 : 8'h88);
      chk(test_one_analog, r[0] ? 8'h35 : 8'h31);
      chk(reserved_cfg_b, 8'h7F);
      chk(reserved_cfg_c, 8'h3F);
      chk(test_zero_value, 8'h0B);
      rd(6'h2C, 8'h88);
      rd(6'h2D, 8'h31);
      rd(6'h29, 8'h59);
      rd(6'h2E, 8'h0B);
      rd(6'h26, 8'h7F);
    end
    print_verdict();
  end
endmodule : testbench

bind scti_synth_cal_regs scti_regs_props #(.PART_ID(PART_ID), .REV_ID(REV_ID)) u_props (
  .clock, .srst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data, .sleep_request,
  .converter_retention_setting, .cal_done, .cal_pump_code, .cal_vco_current, .cal_coarse_tune,
  .pump_stage_enable, .pump_current_code, .oscillator_core_high_select, .vco_current_code,
  .coarse_tune_code, .cal_control, .vco_select_stage_enable, .reserved_cfg_a, .test_two_analog,
  .test_one_analog, .asleep);
